//--- linreg_meas_pkg.sv
// Constants for the linear-regulator mask and load-current measurement block
// Behaviour
// - Mask bit 0 lets its event raise an interrupt; 1 suppresses it.
// - Bit 7 gates regulator B power-good-lost into its power-good flag; resets 1.
// - Bit 6 gates regulator B power-good-reached into its power-good flag; resets 1.
// - Bit 4 gates regulator B current-limit into its current-limit flag; resets 0.
// - Bit 3 gates regulator A power-good-lost into its power-good flag; resets 1.
// - Bit 2 gates regulator A power-good-reached into its power-good flag; resets 1.
// - Bit 0 gates regulator A current-limit into its current-limit flag; read/write.
// - Masks affect only interrupts; status bits track live conditions.
// - Select bit 0 picks converter: 0 first buck, 1 second; resets 0.
// - Any write to the select register starts a new measurement.
// - Result bit 8 sits at high register bit 0; other bits read zero.
// - Result bits 7:0 sit in low register; both result registers read-only.
// - Result scale is 20 mA per LSB, 10.22 A full scale.
// - Completed measurement raises a ready flag, gated by its own mask bit.
package linreg_meas_pkg;
    // ****************************************
    // Register addresses
    // ****************************************
    localparam logic [7:0] ADDR_MASK    = 8'h23;
    localparam logic [7:0] ADDR_SELECT  = 8'h24;
    localparam logic [7:0] ADDR_RES_HI  = 8'h25;
    localparam logic [7:0] ADDR_RES_LO  = 8'h26;
    // ****************************************
    // Mask register fields
    // ****************************************
    localparam int BIT_B_PG_FALL = 7;
    localparam int BIT_B_PG_RISE = 6;
    localparam int BIT_B_CURLIM  = 4;
    localparam int BIT_A_PG_FALL = 3;
    localparam int BIT_A_PG_RISE = 2;
    localparam int BIT_A_CURLIM  = 0;
    localparam logic [7:0] MASK_WRITABLE = 8'hdd;
    localparam logic [7:0] MASK_RESET    = 8'hcc;
    // ****************************************
    // Select and result fields
    // ****************************************
    localparam int         BIT_SELECT   = 0;
    localparam logic       SELECT_RESET = 1'h0;
    localparam int         RESULT_W     = 9;
    localparam int         RESULT_MSB   = 8;
    localparam int         LSB_MA       = 20;
    localparam int         FULL_MA      = 10220;
    localparam logic [8:0] RESULT_RESET = 9'h000;
endpackage

//--- linreg_irq_gate.sv
// Masked interrupt flag generation for one linear regulator
`timescale 1ns/1ps
module linreg_irq_gate (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic pg_state,
    input  wire logic curlim_state,
    input  wire logic pg_fall_mask,
    input  wire logic pg_rise_mask,
    input  wire logic curlim_mask,
    input  wire logic pg_irq_clear,
    input  wire logic curlim_irq_clear,
    output logic      pg_irq,
    output logic      curlim_irq
);
    logic pg_prev;
    logic cl_prev;
    logic pg_event;
    logic cl_event;

    // Prev takes the live level in reset, so release makes no false edge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pg_prev <= pg_state;
            cl_prev <= curlim_state;
        end else begin
            pg_prev <= pg_state;
            cl_prev <= curlim_state;
        end
    end

    // Edges gated by mask; 0 passes, 1 suppresses
    assign pg_event = (!pg_state && pg_prev && !pg_fall_mask)
                    || (pg_state && !pg_prev && !pg_rise_mask);
    assign cl_event = curlim_state && !cl_prev && !curlim_mask;

    // Set wins over clear so an event in the clear cycle is kept
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pg_irq <= 1'h0;
        end else if (pg_event) begin
            pg_irq <= 1'h1;
        end else if (pg_irq_clear) begin
            pg_irq <= 1'h0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            curlim_irq <= 1'h0;
        end else if (cl_event) begin
            curlim_irq <= 1'h1;
        end else if (curlim_irq_clear) begin
            curlim_irq <= 1'h0;
        end
    end

    masked_event_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (cl_event |=> curlim_irq)) else $error("Current-limit event lost");
endmodule

//--- load_meas_ctrl.sv
// Load-current measurement start, capture and ready flag
`timescale 1ns/1ps
module load_meas_ctrl #(
    parameter int RESULT_W = linreg_meas_pkg::RESULT_W
) (
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                start,
    input  wire logic                sel_in,
    input  wire logic                done,
    input  wire logic [RESULT_W-1:0] sample,
    input  wire logic                ready_clear,
    output logic                     busy,
    output logic                     meas_sel,
    output logic [RESULT_W-1:0]      result,
    output logic                     meas_ready_irq
);
    if (RESULT_W != linreg_meas_pkg::RESULT_W) begin : g_width_check
        $error("Result width must be 9");
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            busy     <= 1'h0;
            meas_sel <= linreg_meas_pkg::SELECT_RESET;
        end else if (start) begin
            busy     <= 1'h1;
            meas_sel <= sel_in;
        end else if (done) begin
            busy <= 1'h0;
        end
    end

    // Both halves load in one edge, so a read never mixes samples
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            result <= linreg_meas_pkg::RESULT_RESET;
        end else if (busy && done && !start) begin
            result <= sample;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meas_ready_irq <= 1'h0;
        end else if (busy && done && !start) begin
            meas_ready_irq <= 1'h1;
        end else if (ready_clear) begin
            meas_ready_irq <= 1'h0;
        end
    end

    result_hold_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (!(busy && done) |=> $stable(result))) else $error("Result moved");
    start_busy_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (start |=> busy && meas_sel == $past(sel_in)))
        else $error("Start not taken");
endmodule

//--- linreg_mask_and_load_meas_regs.sv
// Mask, measurement select and result registers on the serial control port
`timescale 1ns/1ps
module linreg_mask_and_load_meas_regs (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic       reg_a_pg_live,
    input  wire logic       reg_a_curlim_live,
    input  wire logic       reg_b_pg_live,
    input  wire logic       reg_b_curlim_live,
    output logic [3:0]      linear_reg_status,
    input  wire logic [3:0] linear_reg_irq_clear,
    output logic [3:0]      linear_reg_irq_flags,
    output logic            meas_start,
    output logic            meas_sel,
    output logic            meas_busy,
    input  wire logic       meas_done,
    input  wire logic [8:0] meas_sample,
    input  wire logic       meas_ready_mask,
    input  wire logic       meas_ready_clear,
    output logic            meas_ready_irq,
    output logic            meas_ready_int
);
    // ****************************************
    // Register storage
    // ****************************************
    logic [7:0] linear_reg_irq_mask;
    logic       load_sel;
    logic [8:0] result;
    logic       wr_mask;
    logic       wr_sel;
    logic [7:0] next_rdata;

    assign wr_mask = reg_wr && reg_addr == linreg_meas_pkg::ADDR_MASK;
    assign wr_sel  = reg_wr && reg_addr == linreg_meas_pkg::ADDR_SELECT;

    // Reserved mask bits never store a one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            linear_reg_irq_mask <= linreg_meas_pkg::MASK_RESET;
        end else if (wr_mask) begin
            linear_reg_irq_mask <= reg_wdata
                                 & linreg_meas_pkg::MASK_WRITABLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            load_sel <= linreg_meas_pkg::SELECT_RESET;
        end else if (wr_sel) begin
            load_sel <= reg_wdata[linreg_meas_pkg::BIT_SELECT];
        end
    end

    // Start pulse on every write, even with an unchanged value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meas_start <= 1'h0;
        end else begin
            meas_start <= wr_sel;
        end
    end

    // ****************************************
    // Status is the live condition, untouched by masks
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            linear_reg_status <= 4'h0;
        end else begin
            linear_reg_status <= {reg_b_curlim_live, reg_b_pg_live,
                                  reg_a_curlim_live, reg_a_pg_live};
        end
    end

    // ****************************************
    // Interrupt flags per regulator
    // ****************************************
    linreg_irq_gate gate_a (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .pg_state         (reg_a_pg_live),
        .curlim_state     (reg_a_curlim_live),
        .pg_fall_mask     (linear_reg_irq_mask[linreg_meas_pkg::BIT_A_PG_FALL]),
        .pg_rise_mask     (linear_reg_irq_mask[linreg_meas_pkg::BIT_A_PG_RISE]),
        .curlim_mask      (linear_reg_irq_mask[linreg_meas_pkg::BIT_A_CURLIM]),
        .pg_irq_clear     (linear_reg_irq_clear[0]),
        .curlim_irq_clear (linear_reg_irq_clear[1]),
        .pg_irq           (linear_reg_irq_flags[0]),
        .curlim_irq       (linear_reg_irq_flags[1])
    );

    linreg_irq_gate gate_b (
        .clk_sys          (clk_sys),
        .rst              (rst),
        .pg_state         (reg_b_pg_live),
        .curlim_state     (reg_b_curlim_live),
        .pg_fall_mask     (linear_reg_irq_mask[linreg_meas_pkg::BIT_B_PG_FALL]),
        .pg_rise_mask     (linear_reg_irq_mask[linreg_meas_pkg::BIT_B_PG_RISE]),
        .curlim_mask      (linear_reg_irq_mask[linreg_meas_pkg::BIT_B_CURLIM]),
        .pg_irq_clear     (linear_reg_irq_clear[2]),
        .curlim_irq_clear (linear_reg_irq_clear[3]),
        .pg_irq           (linear_reg_irq_flags[2]),
        .curlim_irq       (linear_reg_irq_flags[3])
    );

    // ****************************************
    // Measurement sequencing
    // ****************************************
    load_meas_ctrl #(
        .RESULT_W (linreg_meas_pkg::RESULT_W)
    ) meas (
        .clk_sys        (clk_sys),
        .rst            (rst),
        .start          (meas_start),
        .sel_in         (load_sel),
        .done           (meas_done),
        .sample         (meas_sample),
        .ready_clear    (meas_ready_clear),
        .busy           (meas_busy),
        .meas_sel       (meas_sel),
        .result         (result),
        .meas_ready_irq (meas_ready_irq)
    );

    // Ready flag reaches the interrupt only while unmasked
    assign meas_ready_int = meas_ready_irq && !meas_ready_mask;

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        next_rdata = 8'h00;
        case (reg_addr)
            linreg_meas_pkg::ADDR_MASK: begin
                next_rdata = linear_reg_irq_mask;
            end
            linreg_meas_pkg::ADDR_SELECT: begin
                next_rdata = {7'h00, load_sel};
            end
            linreg_meas_pkg::ADDR_RES_HI: begin
                // 20 mA per count; 511 counts is 10.22 A
                next_rdata = {7'h00, result[linreg_meas_pkg::RESULT_MSB]};
            end
            linreg_meas_pkg::ADDR_RES_LO: begin
                next_rdata = result[7:0];
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    mask_reserved_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (linear_reg_irq_mask[5] == 1'h0 && linear_reg_irq_mask[1] == 1'h0))
        else $error("Reserved mask bit set");
    mask_write_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (wr_mask |=> linear_reg_irq_mask
            == ($past(reg_wdata) & linreg_meas_pkg::MASK_WRITABLE)))
        else $error("Mask write lost");
    sel_start_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (wr_sel |=> meas_start ##1 meas_busy))
        else $error("Select write did not start");
    sel_value_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (wr_sel |=> ##1 meas_sel
            == $past(reg_wdata[linreg_meas_pkg::BIT_SELECT], 2)))
        else $error("Wrong converter chosen");
    status_live_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (1'b1 |=> linear_reg_status == $past({reg_b_curlim_live,
            reg_b_pg_live, reg_a_curlim_live, reg_a_pg_live})))
        else $error("Status not live");
    hi_read_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (reg_rd && reg_addr == linreg_meas_pkg::ADDR_RES_HI
            |=> reg_rdata[7:1] == 7'h00
            && reg_rdata[0] == $past(result[linreg_meas_pkg::RESULT_MSB])))
        else $error("High result wrong");
    lo_read_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (reg_rd && reg_addr == linreg_meas_pkg::ADDR_RES_LO
            |=> reg_rdata == $past(result[7:0])))
        else $error("Low result wrong");
    ready_gate_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (meas_ready_mask |-> !meas_ready_int))
        else $error("Masked ready leaked");
    fall_mask_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (linear_reg_irq_mask[linreg_meas_pkg::BIT_A_PG_FALL]
            && linear_reg_irq_mask[linreg_meas_pkg::BIT_A_PG_RISE]
            && !linear_reg_irq_flags[0] && !linear_reg_irq_clear[0]
            |=> !linear_reg_irq_flags[0]))
        else $error("Masked power-good raised flag");
    reset_mask_a: assert property (@(posedge clk_sys)
        (rst |=> linear_reg_irq_mask == linreg_meas_pkg::MASK_RESET))
        else $error("Mask reset value wrong");
    // ****************************************
    // Interrupt gating checks
    // ****************************************
    a_fall_set_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($fell(reg_a_pg_live)
            && !linear_reg_irq_mask[linreg_meas_pkg::BIT_A_PG_FALL]
            |=> linear_reg_irq_flags[0]))
        else $error("Power-good loss on A not flagged");
    a_rise_set_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($rose(reg_a_pg_live)
            && !linear_reg_irq_mask[linreg_meas_pkg::BIT_A_PG_RISE]
            |=> linear_reg_irq_flags[0]))
        else $error("Power-good rise on A not flagged");
    a_limit_set_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($rose(reg_a_curlim_live)
            && !linear_reg_irq_mask[linreg_meas_pkg::BIT_A_CURLIM]
            |=> linear_reg_irq_flags[1]))
        else $error("Current limit on A not flagged");
    b_fall_set_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($fell(reg_b_pg_live)
            && !linear_reg_irq_mask[linreg_meas_pkg::BIT_B_PG_FALL]
            |=> linear_reg_irq_flags[2]))
        else $error("Power-good loss on B not flagged");
    b_rise_set_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($rose(reg_b_pg_live)
            && !linear_reg_irq_mask[linreg_meas_pkg::BIT_B_PG_RISE]
            |=> linear_reg_irq_flags[2]))
        else $error("Power-good rise on B not flagged");
    b_limit_set_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($rose(reg_b_curlim_live)
            && !linear_reg_irq_mask[linreg_meas_pkg::BIT_B_CURLIM]
            |=> linear_reg_irq_flags[3]))
        else $error("Current limit on B not flagged");
    a_limit_block_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($rose(reg_a_curlim_live)
            && linear_reg_irq_mask[linreg_meas_pkg::BIT_A_CURLIM]
            && !linear_reg_irq_flags[1] && !linear_reg_irq_clear[1]
            |=> !linear_reg_irq_flags[1]))
        else $error("Masked current limit on A flagged");
    b_limit_block_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        ($rose(reg_b_curlim_live)
            && linear_reg_irq_mask[linreg_meas_pkg::BIT_B_CURLIM]
            && !linear_reg_irq_flags[3] && !linear_reg_irq_clear[3]
            |=> !linear_reg_irq_flags[3]))
        else $error("Masked current limit on B flagged");
    // ****************************************
    // Register port and measurement checks
    // ****************************************
    sel_reset_a: assert property (@(posedge clk_sys)
        (rst |=> load_sel == linreg_meas_pkg::SELECT_RESET))
        else $error("Select reset value wrong");
    meas_reset_a: assert property (@(posedge clk_sys)
        (rst |=> result == linreg_meas_pkg::RESULT_RESET
            && !meas_ready_irq && !meas_busy && !meas_start
            && linear_reg_irq_flags == 4'h0 && reg_rdata == 8'h00))
        else $error("Reset value wrong");
    mask_read_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (reg_rd && reg_addr == linreg_meas_pkg::ADDR_MASK
            |=> reg_rdata == $past(linear_reg_irq_mask)))
        else $error("Mask read wrong");
    sel_read_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (reg_rd && reg_addr == linreg_meas_pkg::ADDR_SELECT
            |=> reg_rdata == {7'h00, $past(load_sel)}))
        else $error("Select read wrong");
    unmapped_read_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (reg_rd && (reg_addr < linreg_meas_pkg::ADDR_MASK
            || reg_addr > linreg_meas_pkg::ADDR_RES_LO)
            |=> reg_rdata == 8'h00))
        else $error("Unmapped read not zero");
    ready_set_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (meas_busy && meas_done && !meas_start
            |=> meas_ready_irq && result == $past(meas_sample)))
        else $error("Completed sample not taken");
    ready_clear_a: assert property (@(posedge clk_sys)
        disable iff (rst)
        (meas_ready_clear && !(meas_busy && meas_done)
            |=> !meas_ready_irq))
        else $error("Ready flag not cleared");
endmodule

//--- tb.sv
// Self-checking testbench for the mask and load-measurement registers
`timescale 1ns/1ps
module tb;
    // ****************************************
    // Signals and design instance
    // ****************************************
    logic       clk_sys;
    logic       rst;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [3:0] live;
    logic [3:0] status;
    logic [3:0] irq_clear;
    logic [3:0] flags;
    logic       meas_start;
    logic       meas_sel;
    logic       meas_busy;
    logic       meas_done;
    logic [8:0] meas_sample;
    logic       meas_ready_mask;
    logic       meas_ready_clear;
    logic       meas_ready_irq;
    logic       meas_ready_int;
    int         err_count;
    int         num_checks;
    // Event table: mask bit, flag index, rising edge
    int         ev_bit [6] = '{2, 3, 0, 6, 7, 4};
    int         ev_idx [6] = '{0, 0, 1, 2, 2, 3};
    bit         ev_rise [6] = '{1, 0, 1, 1, 0, 1};

    linreg_mask_and_load_meas_regs i_linreg_mask_and_load_meas_regs (
        .clk_sys              (clk_sys),
        .rst                  (rst),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_rdata            (reg_rdata),
        .reg_a_pg_live        (live[0]),
        .reg_a_curlim_live    (live[1]),
        .reg_b_pg_live        (live[2]),
        .reg_b_curlim_live    (live[3]),
        .linear_reg_status    (status),
        .linear_reg_irq_clear (irq_clear),
        .linear_reg_irq_flags (flags),
        .meas_start           (meas_start),
        .meas_sel             (meas_sel),
        .meas_busy            (meas_busy),
        .meas_done            (meas_done),
        .meas_sample          (meas_sample),
        .meas_ready_mask      (meas_ready_mask),
        .meas_ready_clear     (meas_ready_clear),
        .meas_ready_irq       (meas_ready_irq),
        .meas_ready_int       (meas_ready_int)
    );
    // ****************************************
    // Compare, bus and closing tasks
    // ****************************************
    task automatic chk8(input logic [7:0] got, exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h", $time, msg, got);
        end
    endtask
    task automatic chk1(input logic got, exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %b", $time, msg, got);
        end
    endtask
    // Strobe drops one negedge later, so back-to-back calls leave a gap
    task automatic reg_write(input logic [7:0] a, d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_and_map;
        logic [7:0] d;
        reg_read(linreg_meas_pkg::ADDR_MASK, d);
        chk8(d, 8'hcc, "mask reset");
        reg_read(linreg_meas_pkg::ADDR_SELECT, d);
        chk8(d, 8'h00, "select reset");
        reg_read(linreg_meas_pkg::ADDR_RES_HI, d);
        chk8(d, 8'h00, "result high reset");
        reg_read(linreg_meas_pkg::ADDR_RES_LO, d);
        chk8(d, 8'h00, "result low reset");
        reg_write(8'h27, 8'hff);
        reg_read(8'h27, d);
        chk8(d, 8'h00, "unmapped read");
        reg_write(linreg_meas_pkg::ADDR_MASK, 8'hff);
        reg_read(linreg_meas_pkg::ADDR_MASK, d);
        chk8(d, 8'hdd, "mask reserved bits");
        reg_write(linreg_meas_pkg::ADDR_MASK, 8'h22);
        reg_read(linreg_meas_pkg::ADDR_MASK, d);
        chk8(d, 8'h00, "mask cleared");
    endtask
    // Start level is set with every event masked so no stray flag appears
    task automatic irq_case(input int e, input bit masked);
        logic [7:0] m;
        m = 8'hdd;
        if (!masked) m[ev_bit[e]] = 1'b0;
        reg_write(linreg_meas_pkg::ADDR_MASK, 8'hdd);
        @(negedge clk_sys);
        live[ev_idx[e]] = !ev_rise[e];
        repeat (3) @(negedge clk_sys);
        irq_clear = 4'hf;
        @(negedge clk_sys);
        irq_clear = 4'h0;
        reg_write(linreg_meas_pkg::ADDR_MASK, m);
        @(negedge clk_sys);
        live[ev_idx[e]] = ev_rise[e];
        repeat (3) @(negedge clk_sys);
        chk8({4'h0, flags}, masked ? 8'h00 : 8'(1 << ev_idx[e]), "flag");
        chk8({4'h0, status}, {4'h0, live}, "status");
    endtask
    task automatic meas_case(input logic sel, input logic [8:0] s);
        logic [7:0] d;
        bit         seen;
        seen = 0;
        reg_write(linreg_meas_pkg::ADDR_SELECT, {7'h7f, sel});
        for (int n = 0; n < 4 && !seen; n++) begin
            if (meas_start === 1'b1) seen = 1;
            else @(negedge clk_sys);
        end
        chk1(seen, 1'b1, "start pulse");
        @(negedge clk_sys);
        chk1(meas_busy, 1'b1, "busy");
        chk1(meas_sel, sel, "converter");
        meas_done = 1'b1;
        meas_sample = s;
        @(negedge clk_sys);
        meas_done = 1'b0;
        meas_sample = ~s;
        chk1(meas_busy, 1'b0, "idle");
        chk1(meas_ready_irq, 1'b1, "ready flag");
        chk1(meas_ready_int, 1'b1, "ready unmasked");
        meas_ready_mask = 1'b1;
        #1 chk1(meas_ready_int, 1'b0, "ready masked");
        reg_read(linreg_meas_pkg::ADDR_SELECT, d);
        chk8(d, {7'h00, sel}, "select");
        reg_write(linreg_meas_pkg::ADDR_RES_HI, 8'hfe);
        reg_write(linreg_meas_pkg::ADDR_RES_LO, ~s[7:0]);
        // A done pulse while idle must not disturb the held sample
        meas_done = 1'b1;
        @(negedge clk_sys);
        meas_done = 1'b0;
        reg_read(linreg_meas_pkg::ADDR_RES_HI, d);
        chk8(d, {7'h00, s[8]}, "result high");
        reg_read(linreg_meas_pkg::ADDR_RES_LO, d);
        chk8(d, s[7:0], "result low");
        meas_ready_clear = 1'b1;
        meas_ready_mask = 1'b0;
        @(negedge clk_sys);
        meas_ready_clear = 1'b0;
        chk1(meas_ready_irq, 1'b0, "ready cleared");
    endtask
    // Edge and clear in one cycle: the flag must still be set
    task automatic t_set_wins;
        reg_write(linreg_meas_pkg::ADDR_MASK, 8'h00);
        live[1] = 1'b0;
        @(negedge clk_sys);
        live[1] = 1'b1;
        irq_clear = 4'h2;
        @(negedge clk_sys);
        irq_clear = 4'h0;
        chk8({4'h0, flags}, 8'h02, "set beats clear");
        irq_clear = 4'h2;
        @(negedge clk_sys);
        irq_clear = 4'h0;
        chk8({4'h0, flags}, 8'h00, "flag cleared");
    endtask
    // ****************************************
    // Clock, reset, sequence and watchdog
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, meas_done, meas_ready_mask} = 4'h0;
        meas_ready_clear = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        live = 4'h0;
        irq_clear = 4'h0;
        meas_sample = 9'h000;
        err_count = 0;
        num_checks = 0;
        repeat (2) @(negedge clk_sys);
        rst = 1'b0;
        t_reset_and_map();
        for (int e = 0; e < 6; e++) begin
            irq_case(e, 1'b0);
            irq_case(e, 1'b1);
        end
        meas_case(1'b0, 9'h0a5);
        meas_case(1'b1, 9'(linreg_meas_pkg::FULL_MA / 20));
        t_set_wins();
        results();
    end
    // Whole sequence needs a few hundred cycles; this is far beyond it
    initial begin
        #200000;
        err_count++;
        results();
    end
endmodule
